// >>> logic/poll_cfg.svh
// Constants of the erase status poller: offsets, field layout, timing
// Overview of operation
// - A select bit picks the core-clock delay field or the slow-clock resume delay count as the pre-poll timer.
// - A zero core-clock delay lets the status read start with no waiting.
// - A nonzero delay holds the status read off for at least that many clock cycles after the erase command ends.
// - A polarity bit says whether a busy bit of 0 or of 1 means the flash is busy.
// - A three-bit field picks which bit of the received status byte is the busy bit.
// - The receive phase uses single, dual or quad lanes as its two-bit field says, code 11 reserved.
// - The instruction phase uses single, dual or quad lanes as its own two-bit field says, code 11 reserved.
// - The instruction phase shifts out the eight-bit opcode held in the command register.
// - Any write to the erase-check register while an erase runs makes the block read the flash status.
// - After that status read the erase-in-progress flag is updated from the sampled busy bit.
`ifndef POLL_CFG_SVH
`define POLL_CFG_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_STATUS_CMD   32'h0c000034
`define ADDR_ERASE_CHECK  32'h0c000038
`define ADDR_POLL_STATE   32'h0c0000f0
`define ADDR_RESUME_DLY   32'h0c0000f4

// ----------------------------------------------------------------------
// Command register layout
// ----------------------------------------------------------------------
`define CMD_RESET         32'h00000000
`define CMD_MASK          32'h007fffff
`define DLY_SEL_BIT       22
`define DLY_HI            21
`define DLY_LO            16
`define POL_BIT           15
`define POS_HI            14
`define POS_LO            12
`define RXMD_HI           11
`define RXMD_LO           10
`define TXMD_HI           9
`define TXMD_LO           8
`define OP_HI             7
`define OP_LO             0
`define RESUME_RESET      8'h00

// ----------------------------------------------------------------------
// Serial timing: core cycles per half period of the flash clock
// ----------------------------------------------------------------------
`define SCK_HALF          3'h4
`define PHASE_LAST        3'h7

`endif

// >>> logic/poll_pkg.sv
// Types shared by the erase status poller
package poll_pkg;

	typedef enum logic [1:0]
	{
		LANE_SINGLE   = 2'h0,
		LANE_DUAL     = 2'h1,
		LANE_QUAD     = 2'h2,
		LANE_RESERVED = 2'h3
	} lane_mode_e;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h0,
		ST_CMD  = 3'h1,
		ST_RX   = 3'h3,
		ST_DONE = 3'h2
	} poll_state_e;

endpackage : poll_pkg

// >>> logic/sync_edge.sv
// Two-stage synchroniser with rising-edge detection
`timescale 1ns/1ps
module sync_edge
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      level,
	output logic      rise
);

	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			meta <= async_in;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise  = sync & ~prev;

endmodule : sync_edge

// >>> logic/delay_timer.sv
// Loadable down counter that reports when the delay has run out
`timescale 1ns/1ps
module delay_timer
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       load,
	input  wire logic [7:0] load_value,
	input  wire logic       tick,
	output logic            done
);

	logic [7:0] count;

	always_ff @(posedge clk)
	begin
		if (rst)
			count <= 8'h00;
		else if (load)
			count <= load_value;
		else if (tick && count != 8'h00)
			count <= count - 8'h01;
	end

	assign done = (count == 8'h00) && !load;

endmodule : delay_timer

// >>> logic/erase_status_poll.sv
// Erase status poller: register port, pre-poll delay and status read
`timescale 1ns/1ps
`include "poll_cfg.svh"
module erase_status_poll
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic      [31:0] reg_rdata,
	input  wire logic        erase_cmd_done,
	input  wire logic        slow_clk,
	output logic             qspi_sclk,
	output logic             qspi_cs_n,
	input  wire logic [3:0]  qspi_io_in,
	output logic      [3:0]  qspi_io_out,
	output logic      [3:0]  qspi_io_oe_n,
	output logic             erase_in_progress
);

	// ------------------------------------------------------------------
	// Lane helpers
	// ------------------------------------------------------------------
	function automatic logic [2:0] last_slot(poll_pkg::lane_mode_e m);
		case (m)
			poll_pkg::LANE_DUAL: last_slot = 3'h3;
			poll_pkg::LANE_QUAD: last_slot = 3'h1;
			default:             last_slot = 3'h7;
		endcase
	endfunction : last_slot

	// Returns {oe_n, out}; reserved code falls back to one lane
	function automatic logic [7:0] drive_bits(poll_pkg::lane_mode_e m,
		logic [7:0] sr);
		case (m)
			poll_pkg::LANE_DUAL: drive_bits = {4'hc, 2'h0, sr[7:6]};
			poll_pkg::LANE_QUAD: drive_bits = {4'h0, sr[7:4]};
			default:             drive_bits = {4'he, 3'h0, sr[7]};
		endcase
	endfunction : drive_bits

	function automatic logic [7:0] shift_tx(poll_pkg::lane_mode_e m,
		logic [7:0] sr);
		case (m)
			poll_pkg::LANE_DUAL: shift_tx = {sr[5:0], 2'h0};
			poll_pkg::LANE_QUAD: shift_tx = {sr[3:0], 4'h0};
			default:             shift_tx = {sr[6:0], 1'b0};
		endcase
	endfunction : shift_tx

	// Single mode listens on lane 1, the usual data-out pin of the flash
	function automatic logic [7:0] shift_rx(poll_pkg::lane_mode_e m,
		logic [7:0] sr, logic [3:0] io);
		case (m)
			poll_pkg::LANE_DUAL: shift_rx = {sr[5:0], io[1:0]};
			poll_pkg::LANE_QUAD: shift_rx = {sr[3:0], io};
			default:             shift_rx = {sr[6:0], io[1]};
		endcase
	endfunction : shift_rx

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	poll_pkg::poll_state_e state;
	poll_pkg::lane_mode_e  tx_mode;
	poll_pkg::lane_mode_e  rx_mode;
	logic [31:0]           status_cmd;
	logic [7:0]            resume_delay;
	logic                  pending;
	logic                  busy_last;
	logic [2:0]            phase;
	logic [2:0]            slot;
	logic [7:0]            tx_sr;
	logic [7:0]            rx_sr;
	logic [3:0]            io_sync;
	logic                  slow_rise;
	logic                  sel_slow;
	logic                  timer_done;
	logic [7:0]            timer_load;
	logic                  check_write;
	logic                  busy_now;
	logic [2:0]            next_phase;
	logic [7:0]            first_drive;
	logic [7:0]            next_drive;

	assign check_write = reg_we && (reg_addr == `ADDR_ERASE_CHECK);
	assign next_phase  = phase + 3'h1;
	assign first_drive = drive_bits(
		poll_pkg::lane_mode_e'(status_cmd[`TXMD_HI:`TXMD_LO]),
		status_cmd[`OP_HI:`OP_LO]);
	assign next_drive  = drive_bits(tx_mode, tx_sr);
	// Busy when the chosen bit equals the polarity bit
	assign busy_now = rx_sr[status_cmd[`POS_HI:`POS_LO]] ==
		status_cmd[`POL_BIT];

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gen_io_sync
			sync_edge u_io_sync
			(
				.clk      (core_clk),
				.rst      (rst),
				.async_in (qspi_io_in[g]),
				.level    (io_sync[g]),
				.rise     ()
			);
		end
	endgenerate

	sync_edge u_slow_sync
	(
		.clk      (core_clk),
		.rst      (rst),
		.async_in (slow_clk),
		.level    (),
		.rise     (slow_rise)
	);

	// ------------------------------------------------------------------
	// Pre-poll delay
	// ------------------------------------------------------------------
	// The select is latched at load so a later rewrite cannot change
	// the time base of a delay already running
	always_ff @(posedge core_clk)
	begin
		if (rst)
			sel_slow <= 1'b0;
		else if (erase_cmd_done)
			sel_slow <= status_cmd[`DLY_SEL_BIT];
	end

	assign timer_load = status_cmd[`DLY_SEL_BIT] ? resume_delay :
		{2'h0, status_cmd[`DLY_HI:`DLY_LO]};

	delay_timer u_delay
	(
		.clk        (core_clk),
		.rst        (rst),
		.load       (erase_cmd_done),
		.load_value (timer_load),
		.tick       (sel_slow ? slow_rise : 1'b1),
		.done       (timer_done)
	);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
			status_cmd <= `CMD_RESET;
		else if (reg_we && reg_addr == `ADDR_STATUS_CMD)
			status_cmd <= reg_wdata & `CMD_MASK;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			resume_delay <= `RESUME_RESET;
		else if (reg_we && reg_addr == `ADDR_RESUME_DLY)
			resume_delay <= reg_wdata[7:0];
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else if (reg_re)
		begin
			case (reg_addr)
				`ADDR_STATUS_CMD: reg_rdata <= status_cmd;
				`ADDR_POLL_STATE: reg_rdata <= {27'h0, busy_last, pending,
					state != poll_pkg::ST_IDLE, timer_done, erase_in_progress};
				`ADDR_RESUME_DLY: reg_rdata <= {24'h0, resume_delay};
				default:          reg_rdata <= 32'h00000000;
			endcase
		end
		else
			reg_rdata <= 32'h00000000;
	end

	// A new check wins over the clear at the end of a read
	always_ff @(posedge core_clk)
	begin
		if (rst)
			pending <= 1'b0;
		else if (check_write && erase_in_progress)
			pending <= 1'b1;
		else if (state == poll_pkg::ST_DONE)
			pending <= 1'b0;
	end

	// A fresh erase wins over a not-busy result
	always_ff @(posedge core_clk)
	begin
		if (rst)
			erase_in_progress <= 1'b0;
		else if (erase_cmd_done)
			erase_in_progress <= 1'b1;
		else if (state == poll_pkg::ST_DONE && !busy_now)
			erase_in_progress <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			busy_last <= 1'b0;
		else if (state == poll_pkg::ST_DONE)
			busy_last <= busy_now;
	end

	// ------------------------------------------------------------------
	// Status read sequencer
	// ------------------------------------------------------------------
	// Data change as the clock falls and are sampled at the end of the
	// high half, which leaves room for the two synchroniser stages
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state        <= poll_pkg::ST_IDLE;
			tx_mode      <= poll_pkg::LANE_SINGLE;
			rx_mode      <= poll_pkg::LANE_SINGLE;
			phase        <= 3'h0;
			slot         <= 3'h0;
			tx_sr        <= 8'h00;
			rx_sr        <= 8'h00;
			qspi_sclk    <= 1'b0;
			qspi_cs_n    <= 1'b1;
			qspi_io_out  <= 4'h0;
			qspi_io_oe_n <= 4'hf;
		end
		else
		begin
			case (state)
				poll_pkg::ST_IDLE:
				begin
					qspi_sclk <= 1'b0;
					if (pending && timer_done)
					begin
						state   <= poll_pkg::ST_CMD;
						tx_mode <= poll_pkg::lane_mode_e'(
							status_cmd[`TXMD_HI:`TXMD_LO]);
						rx_mode <= poll_pkg::lane_mode_e'(
							status_cmd[`RXMD_HI:`RXMD_LO]);
						phase        <= 3'h0;
						slot         <= 3'h0;
						qspi_cs_n    <= 1'b0;
						qspi_io_oe_n <= first_drive[7:4];
						qspi_io_out  <= first_drive[3:0];
						tx_sr        <= shift_tx(poll_pkg::lane_mode_e'(
							status_cmd[`TXMD_HI:`TXMD_LO]),
							status_cmd[`OP_HI:`OP_LO]);
					end
				end
				poll_pkg::ST_CMD:
				begin
					phase     <= next_phase;
					qspi_sclk <= next_phase >= `SCK_HALF;
					if (phase == `PHASE_LAST)
					begin
						slot <= slot + 3'h1;
						if (slot == last_slot(tx_mode))
						begin
							state        <= poll_pkg::ST_RX;
							slot         <= 3'h0;
							qspi_io_oe_n <= 4'hf;
						end
						else
						begin
							qspi_io_oe_n <= next_drive[7:4];
							qspi_io_out  <= next_drive[3:0];
							tx_sr        <= shift_tx(tx_mode, tx_sr);
						end
					end
				end
				poll_pkg::ST_RX:
				begin
					phase     <= next_phase;
					qspi_sclk <= next_phase >= `SCK_HALF;
					if (phase == `PHASE_LAST)
					begin
						rx_sr <= shift_rx(rx_mode, rx_sr, io_sync);
						slot  <= slot + 3'h1;
						if (slot == last_slot(rx_mode))
						begin
							state     <= poll_pkg::ST_DONE;
							qspi_cs_n <= 1'b1;
						end
					end
				end
				poll_pkg::ST_DONE:
					state <= poll_pkg::ST_IDLE;
				default:
					state <= poll_pkg::ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [7:0] since_load;
	logic [7:0] load_val;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			since_load <= 8'h00;
			load_val   <= 8'h00;
		end
		else if (erase_cmd_done)
		begin
			since_load <= 8'h00;
			load_val   <= timer_load;
		end
		else if (since_load != 8'hff)
			since_load <= since_load + 8'h01;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_zero_delay: assert property (erase_cmd_done &&
		!status_cmd[`DLY_SEL_BIT] &&
		status_cmd[`DLY_HI:`DLY_LO] == 6'h00 |=> timer_done)
		else $error("zero delay did not finish at once");
	chk_delay_min: assert property (timer_done && !sel_slow &&
		since_load != 8'hff |-> since_load >= load_val)
		else $error("status read allowed before delay ran out");
	chk_slow_select: assert property (erase_cmd_done &&
		status_cmd[`DLY_SEL_BIT] && resume_delay > 8'h01
		|=> !timer_done [*2])
		else $error("slow delay ended too early");
	chk_busy_clears: assert property (state == poll_pkg::ST_DONE &&
		rx_sr[status_cmd[`POS_HI:`POS_LO]] != status_cmd[`POL_BIT] &&
		!erase_cmd_done |=> !erase_in_progress)
		else $error("flag not cleared on not-busy");
	chk_busy_keeps: assert property (state == poll_pkg::ST_DONE &&
		rx_sr[status_cmd[`POS_HI:`POS_LO]] == status_cmd[`POL_BIT] &&
		erase_in_progress |=> erase_in_progress)
		else $error("flag cleared while busy");
	chk_check_starts: assert property (check_write && erase_in_progress &&
		status_cmd[`DLY_SEL_BIT] == 1'b0 &&
		status_cmd[`DLY_HI:`DLY_LO] == 6'h00 &&
		!erase_cmd_done && state == poll_pkg::ST_IDLE |=> ##1 !qspi_cs_n)
		else $error("erase check did not start a status read");
	chk_rx_released: assert property (state == poll_pkg::ST_RX
		|-> qspi_io_oe_n == 4'hf)
		else $error("lanes driven during receive");
	chk_single_instr: assert property (state == poll_pkg::ST_CMD &&
		tx_mode == poll_pkg::LANE_SINGLE |-> qspi_io_oe_n == 4'he)
		else $error("single instruction on wrong lanes");
	chk_opcode_msb: assert property ($fell(qspi_cs_n) &&
		tx_mode == poll_pkg::LANE_SINGLE |-> qspi_io_out[0] ==
		$past(status_cmd[`OP_HI]))
		else $error("opcode first bit wrong");

	cov_flag_cleared: cover property ($fell(erase_in_progress));
	cov_quad_read: cover property (state == poll_pkg::ST_RX &&
		rx_mode == poll_pkg::LANE_QUAD);
	cov_slow_delay: cover property (sel_slow && $rose(timer_done));

endmodule : erase_status_poll

// >>> testbench/flash_model.sv
// Behavioural serial flash that answers the status read
`timescale 1ns/1ps
module flash_model
(
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic [3:0] io_line,
	input  wire logic [1:0] tx_mode,
	input  wire logic [1:0] rx_mode,
	input  wire logic [7:0] status,
	output logic      [3:0] drive,
	output logic      [7:0] opcode
);
	int         tx_bits;
	int         rx_bits;
	logic [7:0] shift;

	// Reserved lane code falls back to one lane
	function automatic int lanes(input logic [1:0] mode);
		return (mode == 2'h1) ? 2 : ((mode == 2'h2) ? 4 : 1);
	endfunction : lanes

	initial
	begin
		drive   = 4'h5;
		opcode  = 8'h00;
		tx_bits = 0;
		rx_bits = 0;
	end

	always @(negedge cs_n)
	begin
		tx_bits = 0;
		rx_bits = 0;
		opcode  = 8'h00;
	end

	// Released lines must not hold a stale level, so they toggle
	always @(posedge cs_n)
		drive = ~drive;

	always @(posedge sclk)
		if (!cs_n && tx_bits < 8)
		begin
			case (lanes(tx_mode))
				1: opcode = {opcode[6:0], io_line[0]};
				2: opcode = {opcode[5:0], io_line[1:0]};
				default: opcode = {opcode[3:0], io_line};
			endcase
			tx_bits += lanes(tx_mode);
		end

	// Status leaves after each falling edge once the opcode is in
	always @(negedge sclk)
		if (!cs_n && tx_bits >= 8)
		begin
			shift = status << rx_bits;
			drive = ~drive;
			if (rx_bits < 8)
			begin
				case (lanes(rx_mode))
					1: drive[1] = shift[7];
					2: drive[1:0] = shift[7:6];
					default: drive = shift[7:4];
				endcase
			end
			rx_bits += lanes(rx_mode);
		end
endmodule : flash_model

// >>> testbench/test_erase_status_poll.sv
// Self-checking bench for the erase status poller
`timescale 1ns/1ps
`include "poll_cfg.svh"
`define CHECK(nm, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) \
		begin \
			fail_count++; \
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
		end \
	end
module test_erase_status_poll;
	logic        core_clk;
	logic        rst;
	logic [31:0] reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_we;
	logic        reg_re;
	logic [31:0] reg_rdata;
	logic        erase_cmd_done;
	logic        slow_clk;
	logic        qspi_sclk;
	logic        qspi_cs_n;
	logic [3:0]  io_wire;
	logic [3:0]  flash_drive;
	logic [3:0]  qspi_io_out;
	logic [3:0]  qspi_io_oe_n;
	logic        erase_in_progress;
	logic [31:0] cmd_now;
	logic [7:0]  flash_status;
	logic [7:0]  opcode;
	logic [31:0] rd;
	int          fail_count = 0;
	int          cmp_count  = 0;
	int          cycles     = 0;

	// Each lane carries whoever has its output enabled
	assign io_wire = (qspi_io_out & ~qspi_io_oe_n) | (flash_drive & qspi_io_oe_n);

	erase_status_poll dut
	(
		.core_clk          (core_clk),
		.rst               (rst),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_we            (reg_we),
		.reg_re            (reg_re),
		.reg_rdata         (reg_rdata),
		.erase_cmd_done    (erase_cmd_done),
		.slow_clk          (slow_clk),
		.qspi_sclk         (qspi_sclk),
		.qspi_cs_n         (qspi_cs_n),
		.qspi_io_in        (io_wire),
		.qspi_io_out       (qspi_io_out),
		.qspi_io_oe_n      (qspi_io_oe_n),
		.erase_in_progress (erase_in_progress)
	);

	flash_model flash
	(
		.sclk    (qspi_sclk),
		.cs_n    (qspi_cs_n),
		.io_line (io_wire),
		.tx_mode (cmd_now[9:8]),
		.rx_mode (cmd_now[11:10]),
		.status  (flash_status),
		.drive   (flash_drive),
		.opcode  (opcode)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	initial
	begin
		slow_clk = 1'b0;
		forever #100 slow_clk = ~slow_clk;
	end

	// ------------------------------------------------------------------
	// Bus tasks and closing
	// ------------------------------------------------------------------
	task automatic reg_write(input logic [31:0] addr, input logic [31:0] data);
		@(posedge core_clk);
		reg_addr  <= addr;
		reg_wdata <= data;
		reg_we    <= 1'b1;
		@(posedge core_clk);
		reg_we    <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [31:0] addr, output logic [31:0] data);
		@(posedge core_clk);
		reg_addr <= addr;
		reg_re   <= 1'b1;
		@(posedge core_clk);
		reg_re   <= 1'b0;
		@(negedge core_clk);
		data = reg_rdata;
	endtask : reg_read

	task automatic test_done;
		if (fail_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			test_done();
		end
	end

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic test_regs;
		reg_read(`ADDR_STATUS_CMD, rd);
		`CHECK("command reset", 32'h00000000, rd)
		reg_read(`ADDR_RESUME_DLY, rd);
		`CHECK("resume reset", 32'h00000000, rd)
		reg_read(`ADDR_ERASE_CHECK, rd);
		`CHECK("check reads zero", 32'h00000000, rd)
		reg_read(`ADDR_POLL_STATE, rd);
		`CHECK("state at reset", 32'h00000002, rd)
		reg_read(32'h0c000040, rd);
		`CHECK("unmapped read", 32'h00000000, rd)
		reg_write(`ADDR_STATUS_CMD, 32'hffffffff);
		reg_read(`ADDR_STATUS_CMD, rd);
		`CHECK("command width", 32'h007fffff, rd)
		reg_write(`ADDR_RESUME_DLY, 32'h000001a5);
		reg_read(`ADDR_RESUME_DLY, rd);
		`CHECK("resume width", 32'h000000a5, rd)
		`CHECK("flag at reset", 1'b0, erase_in_progress)
	endtask : test_regs

	task automatic test_ignored;
		int low;
		low = 0;
		reg_write(`ADDR_ERASE_CHECK, 32'hffffffff);
		repeat (12)
		begin
			@(negedge core_clk);
			if (qspi_cs_n !== 1'b1)
				low++;
		end
		`CHECK("check without erase", 0, low)
	endtask : test_ignored

	// Cycles counted from the edge that takes the erase-done pulse
	task automatic test_poll(input logic [31:0] cmd, input logic [7:0] stat,
		input int lo, input int hi, input int len, input logic flag);
		int n;
		int m;
		cmd_now      = cmd;
		flash_status = stat;
		reg_write(`ADDR_STATUS_CMD, cmd);
		@(posedge core_clk);
		erase_cmd_done <= 1'b1;
		@(posedge core_clk);
		erase_cmd_done <= 1'b0;
		reg_write(`ADDR_ERASE_CHECK, cmd);
		n = 1;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (qspi_cs_n !== 1'b0 && n < 400);
		`CHECK("delay lower bound", 1'b1, n >= lo)
		`CHECK("delay upper bound", 1'b1, n <= hi)
		`CHECK("flag set", 1'b1, erase_in_progress)
		m = 0;
		while (qspi_cs_n === 1'b0 && m < 1000)
		begin
			@(negedge core_clk);
			m++;
		end
		`CHECK("frame length", len, m)
		`CHECK("flag held", 1'b1, erase_in_progress)
		repeat (3) @(negedge core_clk);
		`CHECK("opcode", cmd[7:0], opcode)
		`CHECK("flag update", flag, erase_in_progress)
		reg_read(`ADDR_POLL_STATE, rd);
		`CHECK("poll state", {27'h0, flag, 3'h1, flag}, rd)
	endtask : test_poll

	initial
	begin
		rst            = 1'b1;
		reg_addr       = 32'h00000000;
		reg_wdata      = 32'h00000000;
		reg_we         = 1'b0;
		reg_re         = 1'b0;
		erase_cmd_done = 1'b0;
		cmd_now        = 32'h00000000;
		flash_status   = 8'h00;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		test_regs();
		test_ignored();
		test_poll(32'h00008005, 8'h01, 3, 3, 128, 1'b1);
		test_poll(32'h000075a5, 8'h7f, 3, 3, 64, 1'b1);
		test_poll(32'h0000ba3c, 8'hf7, 3, 3, 32, 1'b0);
		test_poll(32'h00006f96, 8'h40, 3, 3, 128, 1'b0);
		test_poll(32'h0014d29f, 8'h20, 20, 24, 80, 1'b1);
		reg_write(`ADDR_RESUME_DLY, 32'h00000003);
		test_poll(32'h00401470, 8'hfd, 16, 32, 96, 1'b1);
		test_done();
	end
endmodule : test_erase_status_poll
